// ### logic/hcb_config_bytes.sv
// Purpose: Hub configuration bytes behind an AXI4-Lite slave, with reported settings
// Assumes: One write and one read in flight at most; straps synchronous and steady
// Notes:   Unmapped addresses answer SLVERR; reads of status show the supply sequence
`timescale 1ns/1ps
`default_nettype none
`include "hcb_consts.svh"
module hcb_config_bytes
	import hcb_pkg::*;
#(
	parameter int ADDR_W      = 8,
	parameter int OC_CYC_W    = 21,
	parameter int OC_DLY0_CYC = `HCB_OC_T0_US * `HCB_CLK_MHZ,
	parameter int OC_DLY1_CYC = `HCB_OC_T1_US * `HCB_CLK_MHZ,
	parameter int OC_DLY2_CYC = `HCB_OC_T2_US * `HCB_CLK_MHZ,
	parameter int OC_DLY3_CYC = `HCB_OC_T3_US * `HCB_CLK_MHZ,
	parameter int DISC_CYCLES = `HCB_DISC_T_US * `HCB_CLK_MHZ
)(
	input  wire logic                clock_in,
	input  wire logic                rstn_in,
	input  wire logic                ce_in,
	// AXI4-Lite write address
	input  wire logic [ADDR_W-1:0]   s_axi_awaddr_in,
	input  wire logic                s_axi_awvalid_in,
	output logic                     s_axi_awready_out,
	// AXI4-Lite write data
	input  wire logic [31:0]         s_axi_wdata_in,
	input  wire logic [3:0]          s_axi_wstrb_in,
	input  wire logic                s_axi_wvalid_in,
	output logic                     s_axi_wready_out,
	// AXI4-Lite write response
	output logic [1:0]               s_axi_bresp_out,
	output logic                     s_axi_bvalid_out,
	input  wire logic                s_axi_bready_in,
	// AXI4-Lite read address
	input  wire logic [ADDR_W-1:0]   s_axi_araddr_in,
	input  wire logic                s_axi_arvalid_in,
	output logic                     s_axi_arready_out,
	// AXI4-Lite read data
	output logic [31:0]              s_axi_rdata_out,
	output logic [1:0]               s_axi_rresp_out,
	output logic                     s_axi_rvalid_out,
	input  wire logic                s_axi_rready_in,
	// Board inputs
	input  wire logic                local_supply_present_in,
	input  wire logic [1:0]          fixed_port_straps_in,
	// Settings as reported to the host side of the hub
	output logic                     dynamic_en_out,
	output logic [OC_CYC_W-1:0]      overcurrent_delay_cycles_out,
	output logic                     compound_report_out,
	output logic                     port_renumber_en_out,
	output hcb_ind_mode_e            indicator_mode_out,
	output logic                     indicator_support_out,
	output logic                     string_en_out,
	output logic [7:0]               fixed_device_ports_out,
	// Supply sequence
	output logic                     self_powered_out,
	output logic                     downstream_power_en_out,
	output logic                     downstream_connect_out,
	output logic                     upstream_attach_out
);

	// Map a byte address onto a register; used by both read and write paths
	function automatic hcb_reg_e decode(input logic [ADDR_W-1:0] addr);
		hcb_reg_e r;
		r = HCB_REG_NONE;
		if (addr[1:0] == 2'b00)
		begin
			unique case (addr[ADDR_W-1:2])
				(ADDR_W-2)'(`HCB_IDX_CFG_TWO):     r = HCB_REG_CFG_TWO;
				(ADDR_W-2)'(`HCB_IDX_CFG_THREE):   r = HCB_REG_CFG_THREE;
				(ADDR_W-2)'(`HCB_IDX_FIXED_PORTS): r = HCB_REG_FIXED;
				(ADDR_W-2)'(`HCB_IDX_STATUS):      r = HCB_REG_STATUS;
				(ADDR_W-2)'(`HCB_IDX_CONTROL):     r = HCB_REG_CONTROL;
				default:                           r = HCB_REG_NONE;
			endcase
		end
		return r;
	endfunction

	// Indicator field decode, shared by mode and support reporting
	// only 01 is speed
	function automatic hcb_ind_mode_e ind_decode(input logic [1:0] sel);
		return (sel == 2'b01) ? HCB_IND_SPEED : HCB_IND_USB;
	endfunction

	// Stored configuration bytes
	logic [7:0]         cfg_two;        // Supply switching, delay, compound
	logic [7:0]         cfg_three;      // Renumber, indicators, strings
	logic [7:0]         fixed_ports;    // Non-removable port mask
	logic [7:0]         control;        // Configuration source

	// Write channel holding registers
	logic               aw_held;        // Address accepted, waiting for data
	logic [ADDR_W-1:0]  aw_addr;        // Held write address
	logic               w_held;         // Data accepted, waiting for address
	logic [31:0]        w_data;         // Held write data
	logic [3:0]         w_strb;         // Held byte enables
	logic               wr_fire;        // Both halves present
	hcb_reg_e           wr_reg;         // Write target
	hcb_reg_e           rd_reg;         // Read target

	// Derived configuration
	logic               use_default;    // Straps rule the fixed ports
	logic [7:0]         strap_ports;    // Ports picked by the straps
	logic [7:0]         eff_ports;      // Ports reported as non-removable
	logic               eff_compound;   // Compound device as reported
	hcb_pwr_state_e     pwr_state;      // Sequencer state for status
	logic [7:0]         status;         // Status byte as read

	// Both halves held and no response waiting
	assign wr_fire           = aw_held && w_held && !s_axi_bvalid_out;
	assign wr_reg            = decode(aw_addr);
	assign rd_reg            = decode(s_axi_araddr_in);
	assign use_default       = control[`HCB_POS_USE_DEFAULT];

	// Write address capture; ready is a flop, dropped on take and
	// raised again only when the response leaves
	always_ff @(posedge clock_in)
	begin
		if (!rstn_in)
		begin
			aw_held <= 1'b0;
			aw_addr <= '0;
			s_axi_awready_out <= 1'b1;
		end
		else if (ce_in)
		begin
			if (s_axi_awvalid_in && s_axi_awready_out)
			begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr_in;
				s_axi_awready_out <= 1'b0;
			end
			else if (wr_fire)
				aw_held <= 1'b0;
			else if (s_axi_bvalid_out && s_axi_bready_in)
				s_axi_awready_out <= 1'b1;
		end
	end

	// Write data capture, independent of address order
	always_ff @(posedge clock_in)
	begin
		if (!rstn_in)
		begin
			w_held <= 1'b0;
			w_data <= '0;
			w_strb <= '0;
			s_axi_wready_out <= 1'b1;
		end
		else if (ce_in)
		begin
			if (s_axi_wvalid_in && s_axi_wready_out)
			begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata_in;
				w_strb <= s_axi_wstrb_in;
				s_axi_wready_out <= 1'b0;
			end
			else if (wr_fire)
				w_held <= 1'b0;
			else if (s_axi_bvalid_out && s_axi_bready_in)
				s_axi_wready_out <= 1'b1;
		end
	end

	// Write response; unmapped address gets SLVERR, status writes are ignored
	always_ff @(posedge clock_in)
	begin
		if (!rstn_in)
		begin
			s_axi_bvalid_out <= 1'b0;
			s_axi_bresp_out  <= `HCB_RESP_OKAY;
		end
		else if (ce_in)
		begin
			if (wr_fire)
			begin
				s_axi_bvalid_out <= 1'b1;
				s_axi_bresp_out  <= (wr_reg == HCB_REG_NONE) ? `HCB_RESP_SLVERR : `HCB_RESP_OKAY;
			end
			else if (s_axi_bready_in)
				s_axi_bvalid_out <= 1'b0;
		end
	end

	// Register updates; only byte lane 0 carries data
	always_ff @(posedge clock_in)
	begin
		if (!rstn_in)
		begin
			cfg_two     <= `HCB_RST_CFG_TWO;
			cfg_three   <= `HCB_RST_CFG_THREE;
			fixed_ports <= `HCB_RST_FIXED_PORTS;
			control     <= `HCB_RST_CONTROL;
		end
		else if (ce_in && wr_fire && w_strb[0])
		begin
			unique case (wr_reg)
				HCB_REG_CFG_TWO:   cfg_two   <= w_data[7:0] & `HCB_MASK_CFG_TWO;
				HCB_REG_CFG_THREE: cfg_three <= w_data[7:0] & `HCB_MASK_CFG_THREE;
				HCB_REG_FIXED:     fixed_ports <= w_data[7:0] & `HCB_MASK_FIXED_PORTS;
				HCB_REG_CONTROL:   control   <= w_data[7:0] & 8'h01;
				HCB_REG_STATUS, HCB_REG_NONE:
				begin
					// Read-only or unmapped: nothing stored
				end
			endcase
		end
	end

	// Strap decode: 00 none, 01 port 1, 10 ports 1-2, 11 ports 1-3
	// straps pick fixed ports
	always_comb
	begin
		strap_ports = 8'h00;
		for (int i = 1; i <= 3; i++)
		begin
			if (i <= int'(fixed_port_straps_in))
				strap_ports[i] = 1'b1;
		end
	end

	// Effective fixed ports and compound reporting
	// mask marks non-removable ports
	assign eff_ports = use_default ? strap_ports : fixed_ports;
	assign eff_compound = use_default ? (strap_ports != 8'h00) : cfg_two[`HCB_POS_COMPOUND];

	// Status byte: supply input, mode, attach and sequence state
	assign status = {3'b000, pwr_state == HCB_ST_DETACHED, self_powered_out,
	                 upstream_attach_out, eff_compound, local_supply_present_in};

	// Read channel; data is registered with the valid
	always_ff @(posedge clock_in)
	begin
		if (!rstn_in)
		begin
			s_axi_rvalid_out <= 1'b0;
			s_axi_arready_out <= 1'b1;
			s_axi_rdata_out  <= '0;
			s_axi_rresp_out  <= `HCB_RESP_OKAY;
		end
		else if (ce_in)
		begin
			if (s_axi_arvalid_in && s_axi_arready_out)
			begin
				s_axi_rvalid_out <= 1'b1;
				s_axi_arready_out <= 1'b0;
				s_axi_rresp_out  <= (rd_reg == HCB_REG_NONE) ? `HCB_RESP_SLVERR : `HCB_RESP_OKAY;
				unique case (rd_reg)
					HCB_REG_CFG_TWO:   s_axi_rdata_out <= {24'h00_0000, cfg_two};
					HCB_REG_CFG_THREE: s_axi_rdata_out <= {24'h00_0000, cfg_three};
					HCB_REG_FIXED:     s_axi_rdata_out <= {24'h00_0000, fixed_ports};
					HCB_REG_STATUS:    s_axi_rdata_out <= {24'h00_0000, status};
					HCB_REG_CONTROL:   s_axi_rdata_out <= {24'h00_0000, control};
					HCB_REG_NONE:      s_axi_rdata_out <= 32'h0000_0000;
				endcase
			end
			else if (s_axi_rready_in)
			begin
				s_axi_rvalid_out  <= 1'b0;
				s_axi_arready_out <= 1'b1;
			end
		end
	end

	// Over-current delay in cycles; all four counts are parameters
	// delay field selects time
	always_ff @(posedge clock_in)
	begin
		if (!rstn_in)
			overcurrent_delay_cycles_out <= OC_CYC_W'(OC_DLY0_CYC);
		else if (ce_in)
		begin
			unique case (cfg_two[`HCB_POS_OC_LO +: 2])
				2'b00: overcurrent_delay_cycles_out <= OC_CYC_W'(OC_DLY0_CYC);
				2'b01: overcurrent_delay_cycles_out <= OC_CYC_W'(OC_DLY1_CYC);
				2'b10: overcurrent_delay_cycles_out <= OC_CYC_W'(OC_DLY2_CYC);
				2'b11: overcurrent_delay_cycles_out <= OC_CYC_W'(OC_DLY3_CYC);
			endcase
		end
	end

	// Reported settings, registered so the outputs come from flip-flops
	always_ff @(posedge clock_in)
	begin
		if (!rstn_in)
		begin
			dynamic_en_out         <= 1'b0;
			compound_report_out    <= 1'b0;
			port_renumber_en_out   <= 1'b0;
			indicator_mode_out     <= HCB_IND_USB;
			indicator_support_out  <= 1'b1;
			string_en_out          <= 1'b0;
			fixed_device_ports_out <= 8'h00;
		end
		else if (ce_in)
		begin
			dynamic_en_out         <= cfg_two[`HCB_POS_DYNAMIC];
			compound_report_out    <= eff_compound;
			port_renumber_en_out   <= cfg_three[`HCB_POS_RENUMBER];
			indicator_mode_out     <= ind_decode(cfg_three[`HCB_POS_IND_LO +: 2]);
			indicator_support_out  <= (ind_decode(cfg_three[`HCB_POS_IND_LO +: 2]) == HCB_IND_USB);
			string_en_out          <= cfg_three[`HCB_POS_STRING];
			fixed_device_ports_out <= eff_ports & `HCB_MASK_FIXED_PORTS;
		end
	end

	// Supply mode sequencer
	hcb_power_seq #(
		.DISC_CYCLES (DISC_CYCLES)
	) u_power_seq (
		.clock_in                (clock_in),
		.rstn_in                 (rstn_in),
		.ce_in                   (ce_in),
		.dynamic_en_in           (cfg_two[`HCB_POS_DYNAMIC]),
		.local_supply_present_in (local_supply_present_in),
		.self_powered_out        (self_powered_out),
		.downstream_power_en_out (downstream_power_en_out),
		.downstream_connect_out  (downstream_connect_out),
		.upstream_attach_out     (upstream_attach_out),
		.state_out               (pwr_state)
	);
endmodule
`default_nettype wire

// ### common/hcb_consts.svh
// Purpose: Offsets, field positions, reset values and timing for the hub configuration bytes
// Assumes: 100 MHz clock; AXI4-Lite register access, one aligned word per register
// Notes:   Byte address of a register is four times its index
// Operation
// - Auto supply switching bit forbids or permits changes
// - Switching enabled means watching local supply pin
// - Supply change disconnects downstream, power, upstream
// - Re-attach bus-powered or self-powered by supply
// - Local supply present at attach means self-powered
// - Delay field picks 0.1, 4, 8, 16 ms
// - Combined-device flag reports compound device
// - Strapped non-removable ports imply compound device
// - Renumber bit selects standard or re-map mode
// - Indicator field: 01 speed, others USB
// - Indicator support reported only in USB mode
// - Text descriptor bit disables or enables strings
// - Port byte bits 1-7 mark non-removable ports
// - Port byte bit 0 always zero
// - Default configuration takes fixed ports from straps
`ifndef HCB_CONSTS_SVH
`define HCB_CONSTS_SVH

// Register indices; byte address is index times four
`define HCB_IDX_CFG_TWO      8'h07
`define HCB_IDX_CFG_THREE    8'h08
`define HCB_IDX_FIXED_PORTS  8'h09
`define HCB_IDX_STATUS       8'h10
`define HCB_IDX_CONTROL      8'h11

// Byte two fields
`define HCB_POS_DYNAMIC      7
`define HCB_POS_OC_LO        4
`define HCB_POS_COMPOUND     3
`define HCB_MASK_CFG_TWO     8'hB8
// Byte three fields
`define HCB_POS_RENUMBER     3
`define HCB_POS_IND_LO       1
`define HCB_POS_STRING       0
`define HCB_MASK_CFG_THREE   8'h0F
// Fixed port byte keeps bits 7..1
`define HCB_MASK_FIXED_PORTS 8'hFE
// Control register: use internal default configuration
`define HCB_POS_USE_DEFAULT  0

// Reset values
`define HCB_RST_CFG_TWO      8'h00
`define HCB_RST_CFG_THREE    8'h00
`define HCB_RST_FIXED_PORTS  8'h00
`define HCB_RST_CONTROL      8'h00

// AXI responses
`define HCB_RESP_OKAY        2'b00
`define HCB_RESP_SLVERR      2'b10

// Timing
`define HCB_CLK_MHZ          100
`define HCB_OC_T0_US         100
`define HCB_OC_T1_US         4000
`define HCB_OC_T2_US         8000
`define HCB_OC_T3_US         16000
`define HCB_DISC_T_US        10

`endif

// ### common/hcb_pkg.sv
// Purpose: Types shared by the hub configuration byte logic
// Assumes: Included after hcb_consts.svh where numbers are needed
// Notes:   Types only; all numbers live in the constants header
package hcb_pkg;
	// Supply sequencer states
	typedef enum logic [1:0] {
		HCB_ST_DETACHED,
		HCB_ST_SELF,
		HCB_ST_BUS
	} hcb_pwr_state_e;

	// Indicator pin behaviour as reported
	typedef enum logic {
		HCB_IND_USB,
		HCB_IND_SPEED
	} hcb_ind_mode_e;

	// Register selected by a bus address
	typedef enum logic [2:0] {
		HCB_REG_NONE,
		HCB_REG_CFG_TWO,
		HCB_REG_CFG_THREE,
		HCB_REG_FIXED,
		HCB_REG_STATUS,
		HCB_REG_CONTROL
	} hcb_reg_e;
endpackage

// ### logic/hcb_power_seq.sv
// Purpose: Self/bus-powered selection with disconnect and re-attach on supply change
// Assumes: Local supply input synchronous to the clock
// Notes:   Starts detached after reset and attaches per the supply level
`timescale 1ns/1ps
`default_nettype none
`include "hcb_consts.svh"
module hcb_power_seq
	import hcb_pkg::*;
#(
	parameter int DISC_CYCLES = `HCB_DISC_T_US * `HCB_CLK_MHZ
)(
	input  wire logic       clock_in,
	input  wire logic       rstn_in,
	input  wire logic       ce_in,
	input  wire logic       dynamic_en_in,
	input  wire logic       local_supply_present_in,
	output logic            self_powered_out,
	output logic            downstream_power_en_out,
	output logic            downstream_connect_out,
	output logic            upstream_attach_out,
	output hcb_pwr_state_e  state_out
);
	localparam int CW = $clog2(DISC_CYCLES + 1);

	hcb_pwr_state_e state;      // Current supply mode
	logic [CW-1:0]  hold_cnt;   // Detached time left
	logic           supply_q;   // Supply level at last cycle
	logic           change;     // Supply toggled

	// Edge of the supply level; watched only when switching is allowed
	// watch supply pin
	assign change = dynamic_en_in && (supply_q != local_supply_present_in);

	// Previous supply level
	always_ff @(posedge clock_in)
	begin
		if (!rstn_in)
			supply_q <= 1'b0;
		else if (ce_in)
			supply_q <= local_supply_present_in;
	end

	// Mode sequence
	always_ff @(posedge clock_in)
	begin
		if (!rstn_in)
		begin
			state    <= HCB_ST_DETACHED;
			hold_cnt <= CW'(DISC_CYCLES);
		end
		else if (ce_in)
		begin
			unique case (state)
				HCB_ST_DETACHED:
				begin
					// Hold off long enough for the host to see the detach
					if (hold_cnt != '0)
						hold_cnt <= hold_cnt - 1'b1;
					else if (local_supply_present_in)
						state <= HCB_ST_SELF;
					else
						state <= HCB_ST_BUS;
				end
				HCB_ST_SELF, HCB_ST_BUS:
				begin
					if (change)
					begin
						state    <= HCB_ST_DETACHED;
						hold_cnt <= CW'(DISC_CYCLES);
					end
				end
			endcase
		end
	end

	// Registered outputs follow the current state; a supply change drops power, connect and attach at once
	always_ff @(posedge clock_in)
	begin
		if (!rstn_in)
		begin
			self_powered_out        <= 1'b0;
			downstream_power_en_out <= 1'b0;
			downstream_connect_out  <= 1'b0;
			upstream_attach_out     <= 1'b0;
			state_out               <= HCB_ST_DETACHED;
		end
		else if (ce_in)
		begin
			self_powered_out        <= (state == HCB_ST_SELF);
			downstream_power_en_out <= (state != HCB_ST_DETACHED) && !change;
			downstream_connect_out  <= (state != HCB_ST_DETACHED) && !change;
			upstream_attach_out     <= (state != HCB_ST_DETACHED) && !change;
			state_out               <= state;
		end
	end
endmodule
`default_nettype wire

// ### testbench/hcb_config_props.sv
// Purpose: Checker of reported settings and supply sequence at the top ports
// Assumes: Outputs settle a clock after bvalid rises
// Notes:   Attached by bind at the foot of this file
`timescale 1ns/1ps
`default_nettype none
`include "hcb_consts.svh"
module hcb_config_props
	import hcb_pkg::*;
#(
	parameter int OC_CYC_W    = 21,
	parameter int OC_DLY0_CYC = 1,
	parameter int OC_DLY1_CYC = 2,
	parameter int OC_DLY2_CYC = 3,
	parameter int OC_DLY3_CYC = 4
)(
	input wire logic                clock_in,
	input wire logic                rstn_in,
	input wire logic [7:0]          s_axi_awaddr_in,
	input wire logic                s_axi_awvalid_in,
	input wire logic                s_axi_awready_out,
	input wire logic [31:0]         s_axi_wdata_in,
	input wire logic                s_axi_wvalid_in,
	input wire logic                s_axi_wready_out,
	input wire logic [1:0]          s_axi_bresp_out,
	input wire logic                s_axi_bvalid_out,
	input wire logic [31:0]         s_axi_rdata_out,
	input wire logic                s_axi_rvalid_out,
	input wire logic                local_supply_present_in,
	input wire logic                dynamic_en_out,
	input wire logic [OC_CYC_W-1:0] overcurrent_delay_cycles_out,
	input wire logic                port_renumber_en_out,
	input wire hcb_ind_mode_e       indicator_mode_out,
	input wire logic                indicator_support_out,
	input wire logic                string_en_out,
	input wire logic [7:0]          fixed_device_ports_out,
	input wire logic                self_powered_out,
	input wire logic                downstream_power_en_out,
	input wire logic                downstream_connect_out,
	input wire logic                upstream_attach_out
);
	localparam logic [7:0] A2 = 8'(`HCB_IDX_CFG_TWO * 4);     // Byte two
	localparam logic [7:0] A3 = 8'(`HCB_IDX_CFG_THREE * 4);   // Byte three
	localparam logic [7:0] AF = 8'(`HCB_IDX_FIXED_PORTS * 4); // Fixed ports
	logic [7:0]          aw_q;    // Last taken write address
	logic [31:0]         wd_q;    // Last taken write data
	logic                bv_q;    // Bvalid one cycle back
	logic                wr_done; // First cycle of a clean response
	logic [OC_CYC_W-1:0] oc_exp;  // Delay implied by the last data
	// Last write taken
	always_ff @(posedge clock_in)
	begin
		if (!rstn_in)
		begin
			aw_q <= 8'h00;
			wd_q <= '0;
			bv_q <= 1'b0;
		end
		else
		begin
			if (s_axi_awvalid_in && s_axi_awready_out)
				aw_q <= s_axi_awaddr_in;
			if (s_axi_wvalid_in && s_axi_wready_out)
				wd_q <= s_axi_wdata_in;
			bv_q <= s_axi_bvalid_out;
		end
	end
	assign wr_done = s_axi_bvalid_out && !bv_q && (s_axi_bresp_out == `HCB_RESP_OKAY);
	assign oc_exp = OC_CYC_W'(wd_q[5] ? (wd_q[4] ? OC_DLY3_CYC : OC_DLY2_CYC) : (wd_q[4] ? OC_DLY1_CYC : OC_DLY0_CYC));
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!rstn_in);
	a_support_usb_only: assert property (indicator_support_out == (indicator_mode_out == HCB_IND_USB))
		else $error("indicator support disagrees with mode");
	a_port0_zero: assert property (fixed_device_ports_out[0] == 1'b0)
		else $error("port zero marked fixed");
	a_supply_drop: assert property (dynamic_en_out && $changed(local_supply_present_in)
		|=> !downstream_power_en_out && !downstream_connect_out && !upstream_attach_out)
		else $error("supply change did not detach");
	a_attach_kind: assert property ($rose(upstream_attach_out) |-> self_powered_out == local_supply_present_in)
		else $error("attach kind wrong for supply");
	a_rdata_upper: assert property (s_axi_rvalid_out |-> s_axi_rdata_out[31:8] == 24'h00_0000)
		else $error("read data upper bits set");
	a_dynamic_map: assert property (wr_done && aw_q == A2 |=> dynamic_en_out == wd_q[7])
		else $error("switching enable not taken");
	a_oc_delay_map: assert property (wr_done && aw_q == A2 |=> overcurrent_delay_cycles_out == oc_exp)
		else $error("delay code mapped wrong");
	a_ind_mode_map: assert property (wr_done && aw_q == A3
		|=> indicator_mode_out == ((wd_q[2:1] == 2'b01) ? HCB_IND_SPEED : HCB_IND_USB))
		else $error("indicator code mapped wrong");
	a_cfg3_flags: assert property (wr_done && aw_q == A3
		|=> port_renumber_en_out == wd_q[3] && string_en_out == wd_q[0])
		else $error("renumber or string flag wrong");
	a_fixed_map: assert property (wr_done && aw_q == AF |=> fixed_device_ports_out == {wd_q[7:1], 1'b0})
		else $error("fixed port mask not taken");
endmodule
bind hcb_config_bytes hcb_config_props #(
	.OC_CYC_W    (OC_CYC_W),
	.OC_DLY0_CYC (OC_DLY0_CYC),
	.OC_DLY1_CYC (OC_DLY1_CYC),
	.OC_DLY2_CYC (OC_DLY2_CYC),
	.OC_DLY3_CYC (OC_DLY3_CYC)
) chk_u (.*);
`default_nettype wire

// ### testbench/hcb_host_model.sv
// Purpose: Upstream host that enumerates on each attach
// Assumes: Attach and supply kind are clean levels
// Notes:   Records only what enumeration would see
`timescale 1ns/1ps
`default_nettype none
module hcb_host_model (
	input  wire logic clock_in,
	input  wire logic rstn_in,
	input  wire logic attach_in,
	input  wire logic self_powered_in,
	output logic [7:0] enum_count_out,
	output logic       enum_self_out
);
	logic att_q; // Attach level one cycle back
	// New attach means a fresh enumeration; supply kind read then
	always_ff @(posedge clock_in)
	begin
		if (!rstn_in)
		begin
			att_q <= 1'b0;
			enum_count_out <= 8'h00;
			enum_self_out <= 1'b0;
		end
		else
		begin
			att_q <= attach_in;
			// Only the rising attach counts, a held level does not
			if (attach_in && !att_q)
			begin
				enum_count_out <= enum_count_out + 8'h01;
				enum_self_out <= self_powered_in;
			end
		end
	end
endmodule
`default_nettype wire

// ### testbench/hcb_config_bytes_tb.sv
// Purpose: Register and supply tests of the hub configuration bytes
// Assumes: Short counts set by parameter
// Notes:   Byte reset values unchecked
`timescale 1ns/1ps
`default_nettype none
`include "hcb_consts.svh"
module hcb_config_bytes_tb;
	import hcb_pkg::*;
	localparam int OC [4] = '{1, 2, 3, 4}; // Short delays keep the run brief
	localparam logic [7:0] A2 = 8'(`HCB_IDX_CFG_TWO * 4);
	localparam logic [7:0] A3 = 8'(`HCB_IDX_CFG_THREE * 4);
	localparam logic [7:0] AF = 8'(`HCB_IDX_FIXED_PORTS * 4);
	localparam logic [7:0] AC = 8'(`HCB_IDX_CONTROL * 4);
	logic clock_in, rstn_in, ce_in, s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in;
	logic s_axi_arvalid_in, s_axi_rready_in, local_supply_present_in, host_self;
	logic [7:0] s_axi_awaddr_in, s_axi_araddr_in, fixed_device_ports_out, host_cnt, b;
	logic [31:0] s_axi_wdata_in, s_axi_rdata_out;
	logic [3:0] s_axi_wstrb_in;
	logic [1:0] fixed_port_straps_in, s_axi_bresp_out, s_axi_rresp_out;
	logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out;
	logic dynamic_en_out, compound_report_out, port_renumber_en_out, indicator_support_out, string_en_out;
	logic self_powered_out, downstream_power_en_out, downstream_connect_out, upstream_attach_out;
	logic [20:0] overcurrent_delay_cycles_out;
	hcb_ind_mode_e indicator_mode_out;
	int failures, samples_checked, cyc, i;
	hcb_config_bytes #(.OC_DLY0_CYC(OC[0]), .OC_DLY1_CYC(OC[1]), .OC_DLY2_CYC(OC[2]),
		.OC_DLY3_CYC(OC[3]), .DISC_CYCLES(4)) dut_u (.*);
	hcb_host_model host_u (
		.clock_in        (clock_in),
		.rstn_in         (rstn_in),
		.attach_in       (upstream_attach_out),
		.self_powered_in (self_powered_out),
		.enum_count_out  (host_cnt),
		.enum_self_out   (host_self)
	);
	// Free-running 100 MHz clock
	initial
	begin
		clock_in = 1'b0;
		forever #5 clock_in = ~clock_in;
	end
	// Hang guard, far above the expected run
	always @(posedge clock_in)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			failures++;
			end_sim();
		end
	end
	task automatic end_sim();
		$display("Compared %0d mismatched %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			$display("BAD %s expected %h seen %h", nm, exp, seen);
			failures++;
		end
	endtask
	// Write: both halves offered together, each dropped when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er = 2'b00);
		@(posedge clock_in);
		s_axi_awaddr_in <= a;
		s_axi_wdata_in <= v;
		s_axi_awvalid_in <= 1'b1;
		s_axi_wvalid_in <= 1'b1;
		s_axi_bready_in <= 1'b1;
		repeat (50)
		begin
			@(posedge clock_in);
			if (s_axi_awready_out)
				s_axi_awvalid_in <= 1'b0;
			if (s_axi_wready_out)
				s_axi_wvalid_in <= 1'b0;
			if (s_axi_bvalid_out)
			begin
				chk("bresp", 32'(s_axi_bresp_out), 32'(er));
				s_axi_bready_in <= 1'b0;
				return;
			end
		end
		failures++;
		end_sim();
	endtask
	// Read: address held until taken, rready until data seen
	task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er = 2'b00);
		@(posedge clock_in);
		s_axi_araddr_in <= a;
		s_axi_arvalid_in <= 1'b1;
		s_axi_rready_in <= 1'b1;
		repeat (50)
		begin
			@(posedge clock_in);
			if (s_axi_arready_out)
				s_axi_arvalid_in <= 1'b0;
			if (s_axi_rvalid_out)
			begin
				chk(nm, s_axi_rdata_out, exp);
				chk("rresp", 32'(s_axi_rresp_out), 32'(er));
				s_axi_rready_in <= 1'b0;
				return;
			end
		end
		failures++;
		end_sim();
	endtask
	// Wait for attach, bounded; host sees it one edge later
	task automatic wait_att();
		for (int n = 0; n < 50 && upstream_attach_out !== 1'b1; n++)
			@(posedge clock_in);
		chk("attach", 32'(upstream_attach_out), 32'h1);
		@(posedge clock_in);
	endtask
	initial
	begin
		{rstn_in, s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in, s_axi_arvalid_in, s_axi_rready_in} = '0;
		{s_axi_awaddr_in, s_axi_araddr_in, s_axi_wdata_in} = '0;
		ce_in = 1'b1;
		s_axi_wstrb_in = 4'hF;
		local_supply_present_in = 1'b1;
		fixed_port_straps_in = 2'b10;
		repeat (2) @(posedge clock_in);
		rstn_in <= 1'b1;
		// Power-up attach with supply present
		wait_att();
		chk("self", 32'(self_powered_out), 32'h1);
		// Every delay code, reserved bits set
		for (i = 0; i < 4; i++)
		begin
			b = {i[0], 1'b1, i[1:0], i[1], 3'b111};
			wr(A2, {24'h0, b});
			rd("cfg_two", A2, {24'h0, b & 8'hB8});
			chk("delay", 32'(overcurrent_delay_cycles_out), 32'(OC[i]));
			chk("dynamic", 32'(dynamic_en_out), 32'(i[0]));
			chk("compound", 32'(compound_report_out), 32'(i[1]));
		end
		// Every indicator code with the two flags
		for (i = 0; i < 4; i++)
		begin
			b = {4'hF, i[1], i[1:0], i[0]};
			wr(A3, {24'h0, b});
			rd("cfg_three", A3, {24'h0, b & 8'h0F});
			chk("ind_mode", 32'(indicator_mode_out), 32'(i == 1));
			chk("ind_support", 32'(indicator_support_out), 32'(i != 1));
			chk("renumber", 32'(port_renumber_en_out), 32'(i[1]));
			chk("strings", 32'(string_en_out), 32'(i[0]));
		end
		// Fixed port byte written with all ones; bit 0 reads back zero
		wr(AF, 32'hFF);
		rd("fixed", AF, 32'hFE);
		chk("fixed_out", 32'(fixed_device_ports_out), 32'hFE);
		// Unmapped address answers an error, data zero
		wr(8'h80, 32'h1, `HCB_RESP_SLVERR);
		rd("rdata_bad", 8'h80, 32'h0, `HCB_RESP_SLVERR);
		// Supply loss then return, switching enabled
		for (i = 0; i < 2; i++)
		begin
			local_supply_present_in <= i[0];
			repeat (2) @(posedge clock_in);
			chk("down_power", 32'(downstream_power_en_out), 32'h0);
			chk("down_conn", 32'(downstream_connect_out), 32'h0);
			chk("up_attach", 32'(upstream_attach_out), 32'h0);
			wait_att();
			chk("self", 32'(self_powered_out), 32'(i[0]));
			chk("host_self", 32'(host_self), 32'(i[0]));
		end
		chk("enum_count", 32'(host_cnt), 32'h3);
		// Default mode: straps pick ports, compound follows them
		wr(A2, 32'h0);
		wr(AC, 32'h1);
		rd("control", AC, 32'h1);
		chk("strap_ports", 32'(fixed_device_ports_out), 32'h6);
		chk("strap_comp", 32'(compound_report_out), 32'h1);
		end_sim();
	end
endmodule
`default_nettype wire
